// ### dmx_addr.sv
/*
  file-operand address resolver: bank, access bank or indexed offset.
  assumes purely combinational use within the same clock.
*/
`timescale 1ns/1ns
module dmx_addr (
  // operand
  input  wire logic [7:0]  f,
  input  wire logic        a,
  input  wire logic        ext,
  // context
  input  wire logic [3:0]  bank,
  input  wire logic [11:0] ptr,
  // result
  output logic      [11:0] addr
);

  always_comb begin
    if (!a && ext && (f <= dmx_pkg::IDX_MAX)) begin
      addr = ptr + {4'h0, f};
    end else if (!a) begin
      // low part of bank 0 or high part of the top bank
      addr = (f < dmx_pkg::ACC_SPLIT) ? {4'h0, f} : {dmx_pkg::ACC_HIGH_BANK, f};
    end else begin
      addr = {bank, f};
    end
  end

endmodule : dmx_addr

// ### dmx_core.sv
/*
  execute block for the data-move instruction group, with AHB-Lite slave.
  software pushes 16-bit program words through the instruction register;
  the data space answers a read one clock after dmem_req.re.
*/
`timescale 1ns/1ns
module dmx_core (
  // clock, reset, enable
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              ce,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic      [31:0]       hrdata,
  output logic                   hresp,
  // data space
  output dmx_pkg::dmx_mem_req_t  dmem_req,
  input  wire logic [7:0]        dmem_rdata
);

  dmx_pkg::dmx_state_t state_q;
  logic [15:0] op_q;
  logic [15:0] op2_q;
  logic        sec_q;
  logic [15:0] pend_q;
  logic        pend_v_q;
  logic [7:0]  w_q;
  logic [7:0]  data_q;
  logic [3:0]  bsr_q;
  logic        n_q;
  logic        z_q;
  logic        ext_q;
  logic [11:0] fsr_q [0:dmx_pkg::NUM_PTR-1];
  logic        dph_v_q;
  logic        dph_wr_q;
  logic [7:0]  dph_idx_q;
  logic [1:0]  phase;
  logic        last;
  logic [11:0] bank_addr;
  logic [11:0] ptr2;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  logic is_move_file_reg, is_move_mem_to_mem, is_load_pointer_literal, is_load_bank_literal, is_load_work_literal, two_word, sec_ok;
  logic exec, tick, ex_wr, take, src_is_w;
  logic [7:0]  src_byte;
  logic [11:0] cyc_addr;

  assign is_move_file_reg  = op_q[15:10] == dmx_pkg::OP_MOVE_FILE;
  assign is_move_mem_to_mem = op_q[15:12] == dmx_pkg::OP_MEM_FIRST;
  assign is_load_pointer_literal  = op_q[15:8] == dmx_pkg::OP_LOAD_PTR && op_q[7:6] == dmx_pkg::OP_PTR_PAD;
  assign is_load_bank_literal = op_q[15:8] == dmx_pkg::OP_LOAD_BANK;
  assign is_load_work_literal = op_q[15:8] == dmx_pkg::OP_LOAD_WORK;
  assign two_word = is_move_mem_to_mem || is_load_pointer_literal;
  assign sec_ok   = op2_q[15:12] == dmx_pkg::OP_SECOND;
  assign exec     = state_q == dmx_pkg::ST_EXEC;
  assign tick     = ce && exec;
  assign ex_wr    = tick && last;
  assign ptr2     = fsr_q[2];
  assign take     = ce && pend_v_q && (state_q != dmx_pkg::ST_EXEC);

  dmx_phase u_phase (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .run     (exec),
    .phase   (phase),
    .last    (last)
  );

  dmx_addr u_addr (
    .f    (op_q[7:0]),
    .a    (op_q[dmx_pkg::OP_A_BIT]),
    .ext  (ext_q),
    .bank (bsr_q),
    .ptr  (ptr2),
    .addr (bank_addr)
  );

  // full 12-bit source on the first memory-move word, destination on the second
  assign cyc_addr = sec_q ? op2_q[11:0] : (is_move_mem_to_mem ? op_q[11:0] : bank_addr);
  assign src_is_w = dmem_req.addr == dmx_pkg::WORK_ADDR;
  assign src_byte = src_is_w ? w_q : dmem_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= dmx_pkg::ST_IDLE;
      sec_q   <= 1'b0;
    end else if (ce) begin
      unique case (state_q)
        dmx_pkg::ST_IDLE: begin
          if (pend_v_q) begin
            state_q <= dmx_pkg::ST_EXEC;
            sec_q   <= 1'b0;
          end
        end
        dmx_pkg::ST_EXEC: begin
          if (last) begin
            state_q <= (two_word && !sec_q) ? dmx_pkg::ST_WAIT2 : dmx_pkg::ST_IDLE;
          end
        end
        dmx_pkg::ST_WAIT2: begin
          if (pend_v_q) begin
            state_q <= dmx_pkg::ST_EXEC;
            sec_q   <= 1'b1;
          end
        end
        default: state_q <= dmx_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_q  <= dmx_pkg::RST_OP;
      op2_q <= dmx_pkg::RST_OP;
    end else if (take && state_q == dmx_pkg::ST_IDLE) begin
      op_q <= pend_q;
    end else if (take) begin
      op2_q <= pend_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data space access
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dmem_req <= '0;
      data_q   <= 8'h00;
    end else if (ce) begin
      dmem_req.re <= 1'b0;
      dmem_req.we <= 1'b0;
      if (tick && phase == dmx_pkg::PH_DEC) begin
        dmem_req.addr <= cyc_addr;
        // second memory-move cycle issues no read at all
        dmem_req.re   <= !sec_q && (is_move_file_reg || is_move_mem_to_mem);
      end
      if (tick && phase == dmx_pkg::PH_PROC) begin
        if (!sec_q) begin
          data_q <= src_byte;
        end
        // strobe stands in the fourth phase only
        dmem_req.we    <= !src_is_w && ((is_move_file_reg && op_q[dmx_pkg::OP_D_BIT] && !sec_q)
                          || (is_move_mem_to_mem && sec_q && sec_ok));
        dmem_req.wdata <= sec_q ? data_q : src_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // architectural registers
  logic w_from_data;
  assign w_from_data = (is_move_file_reg && !sec_q && (!op_q[dmx_pkg::OP_D_BIT] || src_is_w))
                       || (is_move_mem_to_mem && sec_q && sec_ok && src_is_w);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      w_q <= dmx_pkg::RST_WORK;
    end else if (ex_wr && is_load_work_literal) begin
      w_q <= op_q[7:0];
    end else if (ex_wr && w_from_data) begin
      w_q <= data_q;
    end else if (ce && dph_v_q && dph_wr_q && dph_idx_q == dmx_pkg::REG_WORK) begin
      w_q <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      n_q <= 1'b0;
      z_q <= 1'b0;
    end else if (ex_wr && is_move_file_reg) begin
      n_q <= data_q[7];
      z_q <= data_q == 8'h00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bsr_q <= dmx_pkg::RST_BANK;
    end else if (ex_wr && is_load_bank_literal) begin
      bsr_q <= op_q[3:0];
    end
  end

  for (genvar i = 0; i < dmx_pkg::NUM_PTR; i++) begin : g_ptr
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        fsr_q[i] <= dmx_pkg::RST_PTR;
      end else if (ex_wr && is_load_pointer_literal && op_q[5:4] == 2'(i) && !sec_q) begin
        fsr_q[i][11:8] <= op_q[3:0];
      end else if (ex_wr && is_load_pointer_literal && op_q[5:4] == 2'(i) && sec_ok) begin
        fsr_q[i][7:0] <= op2_q[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave
  logic ap;
  logic stall;
  logic wr_done;

  assign ap        = hsel && htrans[1] && hready && ce;
  // a second pushed word waits until the core has taken the first
  assign stall     = dph_v_q && dph_wr_q && dph_idx_q == dmx_pkg::REG_INSTR && pend_v_q;
  assign hreadyout = ce && !stall;
  assign hresp     = 1'b0;
  assign wr_done   = dph_v_q && dph_wr_q && hreadyout;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_v_q   <= 1'b0;
      dph_wr_q  <= 1'b0;
      dph_idx_q <= 8'h00;
    end else if (ce && hready) begin
      dph_v_q   <= hsel && htrans[1];
      dph_wr_q  <= hwrite;
      dph_idx_q <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_v_q <= 1'b0;
      pend_q   <= dmx_pkg::RST_OP;
    end else if (wr_done && dph_idx_q == dmx_pkg::REG_INSTR) begin
      pend_v_q <= 1'b1;
      pend_q   <= hwdata[15:0];
    end else if (take) begin
      pend_v_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_q <= 1'b0;
    end else if (wr_done && dph_idx_q == dmx_pkg::REG_CTRL) begin
      ext_q <= hwdata[dmx_pkg::CTRL_EXT_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ap && !hwrite) begin
      unique case (haddr[7:0])
        dmx_pkg::REG_INSTR: hrdata <= {16'h0000, pend_q};
        dmx_pkg::REG_CTRL:  hrdata <= {31'h0000_0000, ext_q};
        dmx_pkg::REG_WORK:  hrdata <= {24'h00_0000, w_q};
        dmx_pkg::REG_STAT:  hrdata <= {28'h000_0000, n_q, z_q,
                                       state_q == dmx_pkg::ST_WAIT2, exec};
        dmx_pkg::REG_BANK:  hrdata <= {28'h000_0000, bsr_q};
        dmx_pkg::REG_PTR0:  hrdata <= {20'h0_0000, fsr_q[0]};
        dmx_pkg::REG_PTR1:  hrdata <= {20'h0_0000, fsr_q[1]};
        dmx_pkg::REG_PTR2:  hrdata <= {20'h0_0000, fsr_q[2]};
        default:            hrdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence mm_first_rd;
    exec && !sec_q && is_move_mem_to_mem && phase == dmx_pkg::PH_DEC && ce;
  endsequence

  sequence mm_second_cyc;
    exec && sec_q && is_move_mem_to_mem && phase == dmx_pkg::PH_DEC && ce;
  endsequence

  wr_phase_a: assert property (dmem_req.we |-> exec && phase == dmx_pkg::PH_WR)
    else $error("data write outside fourth phase");
  load_pointer_literal_high_a: assert property (ex_wr && is_load_pointer_literal && !sec_q && op_q[5:4] == 2'h2
    |=> state_q == dmx_pkg::ST_WAIT2 && ptr2[11:8] == $past(op_q[3:0]))
    else $error("pointer high part not loaded");
  move_file_reg_w_a: assert property (ex_wr && is_move_file_reg && !op_q[dmx_pkg::OP_D_BIT]
    |=> w_q == $past(data_q) && z_q == ($past(data_q) == 8'h00))
    else $error("file move result wrong");
  bank_addr_a: assert property (exec && phase == dmx_pkg::PH_DEC && ce && is_move_file_reg
    && op_q[dmx_pkg::OP_A_BIT] |=> dmem_req.re && dmem_req.addr == {bsr_q, op_q[7:0]})
    else $error("bank address wrong");
  acc_addr_a: assert property (exec && phase == dmx_pkg::PH_DEC && ce && is_move_file_reg
    && !op_q[dmx_pkg::OP_A_BIT] && !ext_q && op_q[7:0] < dmx_pkg::ACC_SPLIT
    |=> dmem_req.addr == {4'h0, op_q[7:0]})
    else $error("access bank address wrong");
  idx_addr_a: assert property (exec && phase == dmx_pkg::PH_DEC && ce && is_move_file_reg
    && !op_q[dmx_pkg::OP_A_BIT] && ext_q && op_q[7:0] <= dmx_pkg::IDX_MAX
    |=> dmem_req.addr == $past(ptr2) + {4'h0, op_q[7:0]})
    else $error("indexed address wrong");
  mm_src_a: assert property (mm_first_rd |=> dmem_req.re && dmem_req.addr == op_q[11:0])
    else $error("memory move source wrong");
  mm_nodummy_a: assert property (mm_second_cyc |=> !dmem_req.re [*3])
    else $error("dummy read in second cycle");
  mm_copy_a: assert property (dmem_req.we && is_move_mem_to_mem
    |-> dmem_req.wdata == data_q && $stable(z_q) && $stable(n_q))
    else $error("memory move altered data or flags");
  load_work_a: assert property (ex_wr && is_load_work_literal
    |=> w_q == $past(op_q[7:0]) && $stable(z_q) && state_q == dmx_pkg::ST_IDLE)
    else $error("literal load wrong");
  load_bank_a: assert property (ex_wr && is_load_bank_literal |=> bsr_q == $past(op_q[3:0]))
    else $error("bank load wrong");

endmodule : dmx_core

// ### dmx_core_bench.sv
/*
  self-checking bench for dmx_core: ahb-lite master tasks, a byte-array
  data space, and a monitor that pops noted results as they appear.
  assumes dmx_pkg and the design modules are compiled first.
*/
`timescale 1ns/1ns
module dmx_core_bench;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  data;
    logic [3:0]  gap;
  } dmx_wexp_t;

  logic                  hclk;
  logic                  hresetn    = 1'b0;
  logic                  ce         = 1'b1;
  logic                  hsel       = 1'b0;
  logic                  hwrite     = 1'b0;
  logic [1:0]            htrans     = 2'h0;
  logic [2:0]            hsize      = 3'h2;
  logic [31:0]           haddr      = 32'h0;
  logic [31:0]           hwdata     = 32'h0;
  logic [7:0]            dmem_rdata = 8'h00;
  logic                  hreadyout;
  logic                  hresp;
  logic [31:0]           hrdata;
  dmx_pkg::dmx_mem_req_t dmem_req;
  logic [7:0]            mem [4096];
  logic [31:0]           rexp_q [$];
  string                 rname_q [$];
  dmx_wexp_t             wexp_q [$];
  dmx_wexp_t             w_now;
  logic                  rd_pend    = 1'b0;
  logic [11:0]           k, ea, sa, da, ptr2;
  logic [7:0]            v, b8;
  logic [7:0]            wv         = 8'h00;
  logic [31:0]           st         = 32'h0;
  logic [7:0]            fv [6]     = '{8'h37, 8'h25, 8'hC3, 8'h5F, 8'h60, 8'hFF};
  logic [5:0]            ext_v      = 6'b011000;
  logic [5:0]            a_v        = 6'b100001;
  logic [5:0]            d_v        = 6'b010110;
  int                    error_cnt  = 0;
  int                    total_checks = 0;
  int                    cyc = 0, re_cyc = 0, re_cnt = 0, n0;

  dmx_core DUT (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .dmem_req(dmem_req),
    .dmem_rdata(dmem_rdata)
  );

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  // entered right after a rising edge; holds each phase until hready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic chk, output logic [31:0] rd);
    int n;
    n = 0;
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 400);
    hsel    <= 1'b0;
    htrans  <= 2'b00;
    hwdata  <= d;
    rd_pend <= chk & ~w;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 400);
    rd = hrdata;
    rd_pend <= 1'b0;
    if (n >= 400) check("bus handshake", 1, 0);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, 1'b0, r);
  endtask : wr

  task automatic push(input logic [15:0] w);
    wr(dmx_pkg::REG_INSTR, {16'h0, w});
  endtask : push

  task automatic expect_rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] r;
    rexp_q.push_back(e);
    rname_q.push_back(nm);
    xfer(1'b0, a, 32'h0, 1'b1, r);
  endtask : expect_rd

  task automatic wait_stat(input logic [31:0] mask, input logic [31:0] want);
    logic [31:0] r;
    int n;
    n = 0;
    // a read issued at once would still see the idle state before the word is taken
    repeat (2) @(posedge hclk);
    do begin xfer(1'b0, dmx_pkg::REG_STAT, 32'h0, 1'b0, r); n++; end
    while ((r & mask) !== want && n < 100);
    if (n >= 100) check("status wait", 1, 0);
  endtask : wait_stat

  ////////////////////////////////////////////////////////////////////////////
  // data space: answers one clock after re; a released line shows no stale byte
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (dmem_req.re) begin
      dmem_rdata <= mem[dmem_req.addr];
      re_cyc <= cyc;
      re_cnt <= re_cnt + 1;
    end else
      dmem_rdata <= ~dmem_rdata;
    if (dmem_req.we) begin
      mem[dmem_req.addr] = dmem_req.wdata;
      if (wexp_q.size() == 0)
        check("unexpected write", 1, 0);
      else begin
        w_now = wexp_q.pop_front();
        check("write addr", dmem_req.addr, w_now.addr);
        check("write data", dmem_req.wdata, w_now.data);
        if (w_now.gap != 0) check("write phase", cyc - re_cyc, w_now.gap);
      end
    end
    if (rd_pend && hreadyout) begin
      check(rname_q.pop_front(), hrdata, rexp_q.pop_front());
      check("response", hresp, 1'b0);
    end
  end

  // limit sized well above the few hundred cycles the sequence needs
  initial begin
    repeat (50000) @(posedge hclk);
    error_cnt++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(86741));
    foreach (mem[i]) mem[i] = 8'($urandom);
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 8; i++) expect_rd(8'(4 * i), 32'h0, "reset value");
    wr(8'h40, $urandom);
    expect_rd(8'h40, 32'h0, "unmapped");
    wr(dmx_pkg::REG_PTR0, 32'hFFFF_FFFF);
    expect_rd(dmx_pkg::REG_PTR0, 32'h0, "read-only pointer");
    // pointers stay below 0x800 so indexed addresses never reach the W location
    for (int p = 0; p < 3; p++) begin
      k = 12'($urandom) & 12'h7FF;
      push({dmx_pkg::OP_LOAD_PTR, dmx_pkg::OP_PTR_PAD, 2'(p), k[11:8]});
      wait_stat(32'h2, 32'h2);
      expect_rd(8'(dmx_pkg::REG_PTR0 + 4 * p), {20'h0, k[11:8], 8'h00}, "ptr high");
      push({dmx_pkg::OP_SECOND, 4'h0, k[7:0]});
      wait_stat(32'h3, 32'h0);
      expect_rd(8'(dmx_pkg::REG_PTR0 + 4 * p), {20'h0, k}, "pointer");
      ptr2 = k;
    end
    b8 = 8'($urandom) | 8'h91;
    push({dmx_pkg::OP_LOAD_BANK, b8});
    wait_stat(32'h3, 32'h0);
    expect_rd(dmx_pkg::REG_BANK, {28'h0, b8[3:0]}, "bank");
    for (int i = 0; i < 6; i++) begin
      if (a_v[i]) ea = {b8[3:0], fv[i]};
      else if (ext_v[i] && fv[i] <= dmx_pkg::IDX_MAX) ea = ptr2 + {4'h0, fv[i]};
      else ea = (fv[i] < dmx_pkg::ACC_SPLIT) ? {4'h0, fv[i]} : {dmx_pkg::ACC_HIGH_BANK, fv[i]};
      v = (i == 1) ? 8'h00 : (i == 2) ? 8'h80 : 8'($urandom);
      mem[ea] = v;
      wr(dmx_pkg::REG_CTRL, {31'h0, ext_v[i]});
      if (d_v[i]) wexp_q.push_back(dmx_wexp_t'{ea, v, 4'h2});
      push({dmx_pkg::OP_MOVE_FILE, d_v[i], a_v[i], fv[i]});
      wait_stat(32'h3, 32'h0);
      if (!d_v[i]) wv = v;
      st = {28'h0, v[7], v == 8'h00, 2'b00};
      expect_rd(dmx_pkg::REG_WORK, {24'h0, wv}, "work");
      expect_rd(dmx_pkg::REG_STAT, st, "flags");
    end
    wv = 8'($urandom);
    push({dmx_pkg::OP_LOAD_WORK, wv});
    // a low enable must only stretch the instruction, not change its result
    ce <= 1'b0;
    repeat (1 + $urandom % 6) @(posedge hclk);
    ce <= 1'b1;
    wait_stat(32'h3, 32'h0);
    expect_rd(dmx_pkg::REG_WORK, {24'h0, wv}, "work literal");
    expect_rd(dmx_pkg::REG_STAT, st, "flags kept");
    wv = 8'($urandom);
    wr(dmx_pkg::REG_WORK, {24'h0, wv});
    expect_rd(dmx_pkg::REG_WORK, {24'h0, wv}, "work bus write");
    // bit 8 cleared keeps both ends off the W and stack-top locations
    for (int i = 0; i < 3; i++) begin
      sa = (i == 1) ? dmx_pkg::WORK_ADDR : 12'($urandom) & 12'hEFF;
      da = (i == 2) ? dmx_pkg::WORK_ADDR : 12'($urandom) & 12'hEFF;
      v = (i == 1) ? wv : mem[sa];
      n0 = re_cnt;
      push({dmx_pkg::OP_MEM_FIRST, sa});
      wait_stat(32'h2, 32'h2);
      check("source read", re_cnt - n0, 1);
      if (i != 2) wexp_q.push_back(dmx_wexp_t'{da, v, 4'h0});
      push({dmx_pkg::OP_SECOND, da});
      wait_stat(32'h3, 32'h0);
      check("no dummy read", re_cnt - n0, 1);
      if (i == 2) wv = v;
      expect_rd(dmx_pkg::REG_WORK, {24'h0, wv}, "work");
      expect_rd(dmx_pkg::REG_STAT, st, "flags");
    end
    repeat (4) @(posedge hclk);
    check("pending results", rexp_q.size() + wexp_q.size(), 0);
    finish_test();
  end
endmodule : dmx_core_bench

// ### dmx_phase.sv
/*
  four-phase sequencer for one instruction cycle.
  assumes run stays high for whole cycles; phase rests at decode otherwise.
*/
`timescale 1ns/1ns
module dmx_phase (
  // clock, reset and enable
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       ce,
  // control
  input  wire logic       run,
  // phase
  output logic      [1:0] phase,
  output logic            last
);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase <= dmx_pkg::PH_DEC;
    end else if (ce) begin
      phase <= run ? phase + 2'h1 : dmx_pkg::PH_DEC;
    end
  end

  assign last = (phase == dmx_pkg::PH_WR);

endmodule : dmx_phase

// ### dmx_pkg.sv
/*
  package for the data-move execute block: register map, opcode fields,
  addressing constants, state codes and the data-space request carrier.
  assumes one 32-bit AHB-Lite slave and a byte-wide data space of 4096 bytes.
*/
package dmx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] REG_INSTR = 8'h00;
  localparam logic [7:0] REG_CTRL  = 8'h04;
  localparam logic [7:0] REG_WORK  = 8'h08;
  localparam logic [7:0] REG_STAT  = 8'h0C;
  localparam logic [7:0] REG_BANK  = 8'h10;
  localparam logic [7:0] REG_PTR0  = 8'h14;
  localparam logic [7:0] REG_PTR1  = 8'h18;
  localparam logic [7:0] REG_PTR2  = 8'h1C;

  // field positions
  localparam int CTRL_EXT_BIT  = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WAIT_BIT = 1;
  localparam int STAT_ZERO_BIT = 2;
  localparam int STAT_NEG_BIT  = 3;

  // reset values
  localparam logic [7:0]  RST_WORK = 8'h00;
  localparam logic [3:0]  RST_BANK = 4'h0;
  localparam logic [11:0] RST_PTR  = 12'h000;
  localparam logic [15:0] RST_OP   = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // opcode fields
  localparam logic [5:0] OP_MOVE_FILE  = 6'h14;
  localparam logic [3:0] OP_MEM_FIRST  = 4'hC;
  localparam logic [3:0] OP_SECOND     = 4'hF;
  localparam logic [7:0] OP_LOAD_PTR   = 8'hEE;
  localparam logic [1:0] OP_PTR_PAD    = 2'h0;
  localparam logic [7:0] OP_LOAD_BANK  = 8'h01;
  localparam logic [7:0] OP_LOAD_WORK  = 8'h0E;
  localparam int         OP_D_BIT      = 9;
  localparam int         OP_A_BIT      = 8;
  localparam int         NUM_PTR       = 3;

  // addressing
  localparam logic [7:0]  ACC_SPLIT     = 8'h60;
  localparam logic [3:0]  ACC_HIGH_BANK = 4'hF;
  localparam logic [7:0]  IDX_MAX       = 8'h5F;
  localparam logic [11:0] WORK_ADDR     = 12'hFE8;

  // instruction phases
  localparam logic [1:0] PH_DEC  = 2'h0;
  localparam logic [1:0] PH_READ = 2'h1;
  localparam logic [1:0] PH_PROC = 2'h2;
  localparam logic [1:0] PH_WR   = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_EXEC  = 3'h2,
    ST_WAIT2 = 3'h4
  } dmx_state_t;

  typedef struct packed {
    logic [11:0] addr;
    logic        re;
    logic        we;
    logic [7:0]  wdata;
  } dmx_mem_req_t;

endpackage : dmx_pkg
